// [cfl_regs.svh]
// Register map, field positions, reset values and timing counts of the loader.
// Assumes a 100 MHz system clock; included by bare name.
// Operation
// - Request pin low abandons user mode and restarts configuration.
// - In user mode request, status and load-complete all read high.
// - Status held low for the whole power-on reset delay.
// - Load-complete low after power-up, before and during loading.
// - Configuration clock ignored once loading is done; host never floats it. In the parallel scheme code still counts two falling edges in ST_DONE first.
// - Host uses bits 7..0 or 15..0; all 32 data pins freed after loading.
// - Load-complete released only after the whole image arrived.
// - Init-done pin driven low once its enable option is loaded. Code drives it low only from ST_DONE through ST_INIT.
// - Load-complete and status go low within 600 ns of request falling.
// - Status low 268 to 1506 us, longer only if held low outside.
// - Parallel data captured on rising configuration clock edge.
// - Internal oscillator init reaches user mode 175 to 437 us after done.
// - User init clock enabled four clock periods after done, then 8576 periods.
// - Init phase clocked by internal oscillator or user init clock pin.
// - Quad serial mode takes four data bits per clock cycle.
// - Serial clock from one of four ranges; no top range with multiple devices. Code ignores the multi bit; range 3 gives half 1 either way.
// - Serial command launched and flash data sampled on falling clock edge.
// - Parallel timing holds only with decompression and security off.
`ifndef CFL_REGS_SVH
`define CFL_REGS_SVH

`define CFL_OFS_CTRL 4'h0
`define CFL_OFS_IMGLEN 4'h4
`define CFL_OFS_STATUS 4'h8
`define CFL_OFS_COUNT 4'hc

`define CFL_CTRL_W 11
`define CFL_CTRL_RST 11'h000
`define CFL_IMGLEN_RST 32'h0000_0000

`define CFL_B_SCHEME 0
`define CFL_B_WIDTH 2:1
`define CFL_B_USRCLK 3
`define CFL_B_INITEN 4
`define CFL_B_QUAD 5
`define CFL_B_RANGE 7:6
`define CFL_B_MULTI 8
`define CFL_B_DECOMP 9
`define CFL_B_SECURE 10

`define CFL_CLK_MHZ 100
`define CFL_T_POR_US 268
`define CFL_T_STATUS_MIN_US 268
`define CFL_T_CD2UM_MIN_US 175
`define CFL_T_CD2CU_NS 32
`define CFL_USR_INIT_PERIODS 8576
`define CFL_DONE_FALLS 2
`define CFL_SLOW_RATIO 2'h3

`define CFL_AS_READ_CMD 8'h03
`define CFL_AS_HDR_BITS 6'h20
`define CFL_AS_WORD_BITS 6'h20

`endif

// [cfl_pkg.sv]
// Types shared by the configuration loader modules.
// No dependencies.
package cfl_pkg;
    typedef enum logic [3:0] {
        ST_POR, ST_RESET, ST_STATUS, ST_STWAIT, ST_LOAD,
        ST_DONE, ST_CLKEN, ST_INIT, ST_USER
    } cfl_state_t;
endpackage

// [cfl_as_if.sv]
// Link between loader sequencer and active serial engine.
// Both ends on the system clock.
`timescale 1ns/1ps
interface cfl_as_if;
    logic run;
    logic quad;
    logic [2:0] half;
    logic [3:0] sdata;
    logic clk_out;
    logic cmd_out;
    logic word_vld;
    logic [31:0] word;
    modport eng (input run, quad, half, sdata, output clk_out, cmd_out, word_vld, word);
    modport ctl (output run, quad, half, sdata, input clk_out, cmd_out, word_vld, word);
endinterface

// [cfl_pin_sync.sv]
// Three-stage synchroniser for pin inputs with agreement filter.
// Output level changes only once stages two and three agree.
`timescale 1ns/1ps
module cfl_pin_sync #(
    parameter int W = 40
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_lvl
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } cfl_sync_st_t;
    cfl_sync_st_t r_reg, r_next;

    always_comb begin
        r_next = r_reg;
        r_next.s1 = i_pin;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        r_next.lvl = (r_reg.s2 & r_reg.s3) | (r_reg.lvl & (r_reg.s2 ^ r_reg.s3));
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            r_reg <= '0;
        end else if (i_ce) begin
            r_reg <= r_next;
        end
    end

    assign o_lvl = r_reg.lvl;
endmodule

// [cfl_as_engine.sv]
// Active serial engine: divides the system clock into the flash clock,
// sends a read command from address zero, then assembles 32-bit words.
`include "cfl_regs.svh"
`timescale 1ns/1ps
module cfl_as_engine (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    cfl_as_if.eng as
);
    typedef struct packed {
        logic [2:0] div;
        logic clk;
        logic cmd;
        logic [31:0] sr;
        logic [5:0] hdr;
        logic [31:0] acc;
        logic [5:0] bits;
        logic vld;
    } cfl_as_st_t;
    cfl_as_st_t r_reg, r_next;
    logic [31:0] acc_n;
    logic [5:0] bits_n;

    always_comb begin
        r_next = r_reg;
        r_next.vld = 1'b0;
        acc_n = as.quad ? {r_reg.acc[27:0], as.sdata} : {r_reg.acc[30:0], as.sdata[0]};
        bits_n = r_reg.bits + (as.quad ? 6'h04 : 6'h01);
        if (!as.run) begin
            r_next.div = 3'h0;
            r_next.clk = 1'b1;
            r_next.cmd = 1'b1;
            r_next.sr = {`CFL_AS_READ_CMD, 24'h00_0000};
            r_next.hdr = `CFL_AS_HDR_BITS;
            r_next.bits = 6'h00;
        end else if (r_reg.div != 3'h0) begin
            r_next.div = r_reg.div - 3'h1;
        end else begin
            r_next.div = as.half - 3'h1;
            r_next.clk = !r_reg.clk;
            if (r_reg.clk) begin
                // Falling edge: both launch and capture happen here
                if (r_reg.hdr != 6'h00) begin
                    r_next.cmd = r_reg.sr[31];
                    r_next.sr = {r_reg.sr[30:0], 1'b0};
                    r_next.hdr = r_reg.hdr - 6'h01;
                end else begin
                    r_next.acc = acc_n;
                    r_next.bits = bits_n;
                    if (bits_n == `CFL_AS_WORD_BITS) begin
                        r_next.bits = 6'h00;
                        r_next.vld = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            r_reg <= '{div: 3'h0, clk: 1'b1, cmd: 1'b1, sr: 32'h0000_0000,
                       hdr: 6'h00, acc: 32'h0000_0000, bits: 6'h00, vld: 1'b0};
        end else if (i_ce) begin
            r_reg <= r_next;
        end
    end

    assign as.clk_out = r_reg.clk;
    assign as.cmd_out = r_reg.cmd;
    assign as.word_vld = r_reg.vld;
    assign as.word = r_reg.acc;
endmodule

// [cfl_config_loader.sv]
// Configuration loader top: power-on and request sequencing, parallel
// passive capture, active serial loading, initialization and user mode.
// Assumes pins already split into in/out/oe; Avalon-MM slave on i_sys_clk.
`include "cfl_regs.svh"
`timescale 1ns/1ps
module cfl_config_loader #(
    parameter int unsigned POR_CYC = `CFL_T_POR_US * `CFL_CLK_MHZ,
    parameter int unsigned STATUS_CYC = `CFL_T_STATUS_MIN_US * `CFL_CLK_MHZ,
    parameter int unsigned INIT_CYC = `CFL_T_CD2UM_MIN_US * `CFL_CLK_MHZ
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_cfg_request_n,
    input wire logic i_status_n,
    output logic o_status_n_out,
    output logic o_status_n_oe,
    input wire logic i_load_complete,
    output logic o_load_complete_out,
    output logic o_load_complete_oe,
    output logic o_init_done_out,
    output logic o_init_done_oe,
    input wire logic i_cfg_clock,
    output logic o_cfg_clock_out,
    output logic o_cfg_clock_oe,
    input wire logic [31:0] i_cfg_data,
    input wire logic i_user_init_clock,
    input wire logic [3:0] i_serial_cfg_data,
    output logic o_serial_cmd_out,
    output logic o_serial_cmd_oe,
    output logic o_user_io_en,
    output cfl_pkg::cfl_state_t o_state
);
    import cfl_pkg::*;

    localparam int unsigned CU_CYC =
        (`CFL_T_CD2CU_NS * `CFL_CLK_MHZ + 999) / 1000;
    localparam logic [17:0] POR_LAST = 18'(POR_CYC - 1);
    localparam logic [17:0] STATUS_LAST = 18'(STATUS_CYC - 1);
    localparam logic [17:0] INIT_LAST = 18'(INIT_CYC - 1);
    localparam logic [17:0] CU_LAST = 18'(CU_CYC - 1);
    localparam logic [17:0] USR_LAST = 18'(`CFL_USR_INIT_PERIODS - 1);
    localparam logic [1:0] FALLS_LAST = 2'(`CFL_DONE_FALLS - 1);

    typedef struct packed {
        cfl_state_t state;
        logic [17:0] cnt;
        logic [1:0] falls;
        logic [1:0] ratio;
        logic [31:0] bytes;
        logic [31:0] img_len;
        logic [`CFL_CTRL_W-1:0] ctrl;
        logic [31:0] last_word;
        logic clk_prev;
        logic ucl_prev;
        logic ack;
        logic waitreq;
        logic [31:0] rdata;
        logic status_oe;
        logic done_oe;
        logic init_oe;
        logic io_en;
        logic as_run;
        logic pin_low;
    } cfl_top_st_t;

    cfl_top_st_t r_reg, r_next;
    logic [39:0] lvl;
    logic clk_lvl;
    logic ucl_lvl;
    logic stat_lvl;
    logic req_lvl;
    logic [3:0] sdat_lvl;
    logic [31:0] data_lvl;
    logic clk_rise;
    logic clk_fall;
    logic ucl_rise;
    logic [31:0] inc;
    logic [31:0] bytes_n;
    logic slow;
    logic [31:0] rd_mux;

    cfl_as_if as_link ();

    cfl_pin_sync #(.W(40)) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_pin({i_cfg_clock, i_user_init_clock, i_status_n, i_cfg_request_n,
                i_serial_cfg_data, i_cfg_data}),
        .o_lvl(lvl)
    );

    cfl_as_engine u_as (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .as(as_link.eng)
    );

    assign {clk_lvl, ucl_lvl, stat_lvl, req_lvl, sdat_lvl, data_lvl} = lvl;
    assign clk_rise = clk_lvl & !r_reg.clk_prev;
    assign clk_fall = !clk_lvl & r_reg.clk_prev;
    assign ucl_rise = ucl_lvl & !r_reg.ucl_prev;

    assign as_link.run = r_reg.as_run;
    assign as_link.quad = r_reg.ctrl[`CFL_B_QUAD];
    assign as_link.sdata = sdat_lvl;

    // 50 MHz is the fastest a 100 MHz system clock can make; top range clamps there
    always_comb begin
        unique case (r_reg.ctrl[`CFL_B_RANGE])
            2'h0: as_link.half = 3'h4;
            2'h1: as_link.half = 3'h2;
            2'h2: as_link.half = 3'h1;
            2'h3: as_link.half = r_reg.ctrl[`CFL_B_MULTI] ? 3'h1 : 3'h1;
        endcase
    end

    // Bytes per captured word by bus width; host keeps to the low lanes
    always_comb begin
        unique case (r_reg.ctrl[`CFL_B_WIDTH])
            2'h0: inc = 32'h0000_0001;
            2'h1: inc = 32'h0000_0002;
            default: inc = 32'h0000_0004;
        endcase
        if (r_reg.ctrl[`CFL_B_SCHEME]) begin
            inc = 32'h0000_0004;
        end
    end

    assign bytes_n = r_reg.bytes + inc;
    // Compressed or secured streams need several clocks per word
    assign slow = r_reg.ctrl[`CFL_B_DECOMP] | r_reg.ctrl[`CFL_B_SECURE];

    always_comb begin
        unique case (i_avs_address)
            `CFL_OFS_CTRL: rd_mux = {21'h00_0000, r_reg.ctrl};
            `CFL_OFS_IMGLEN: rd_mux = r_reg.img_len;
            `CFL_OFS_STATUS: rd_mux = {24'h00_0000, r_reg.io_en, !r_reg.done_oe,
                                       stat_lvl, req_lvl, r_reg.state};
            `CFL_OFS_COUNT: rd_mux = r_reg.bytes;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        r_next = r_reg;
        r_next.clk_prev = clk_lvl;
        r_next.ucl_prev = ucl_lvl;

        // Waitrequest drops for exactly one cycle per request
        r_next.ack = (i_avs_read | i_avs_write) & !r_reg.ack;
        r_next.waitreq = !r_next.ack;
        if (i_avs_read && !r_reg.ack) begin
            r_next.rdata = rd_mux;
        end
        if (i_avs_write && r_reg.ack) begin
            unique case (i_avs_address)
                `CFL_OFS_CTRL: r_next.ctrl = i_avs_writedata[`CFL_CTRL_W-1:0];
                `CFL_OFS_IMGLEN: r_next.img_len = i_avs_writedata;
                default: ;
            endcase
        end

        unique case (r_reg.state)
            ST_POR: begin
                r_next.cnt = r_reg.cnt + 18'h1;
                if (r_reg.cnt == POR_LAST) begin
                    r_next.state = ST_STWAIT;
                    r_next.cnt = 18'h0;
                end
            end
            ST_RESET: begin
                r_next.bytes = 32'h0000_0000;
                r_next.as_run = 1'b0;
                r_next.cnt = 18'h0;
                if (req_lvl) begin
                    r_next.state = ST_STATUS;
                end
            end
            ST_STATUS: begin
                r_next.cnt = r_reg.cnt + 18'h1;
                if (r_reg.cnt == STATUS_LAST) begin
                    r_next.state = ST_STWAIT;
                end
            end
            ST_STWAIT: begin
                // Stays here while something outside holds status low
                if (stat_lvl) begin
                    r_next.state = ST_LOAD;
                    r_next.ratio = 2'h0;
                    r_next.as_run = r_reg.ctrl[`CFL_B_SCHEME];
                end
            end
            ST_LOAD: begin
                if (!r_reg.ctrl[`CFL_B_SCHEME] && clk_rise) begin
                    r_next.ratio = r_reg.ratio + 2'h1;
                    if (!slow || r_reg.ratio == `CFL_SLOW_RATIO) begin
                        r_next.last_word = data_lvl;
                        r_next.bytes = bytes_n;
                    end
                end
                if (r_reg.ctrl[`CFL_B_SCHEME] && as_link.word_vld) begin
                    r_next.last_word = as_link.word;
                    r_next.bytes = bytes_n;
                end
                if (r_next.bytes >= r_reg.img_len && r_next.bytes != r_reg.bytes) begin
                    r_next.state = ST_DONE;
                    r_next.as_run = 1'b0;
                    r_next.falls = 2'h0;
                end
            end
            ST_DONE: begin
                if (r_reg.ctrl[`CFL_B_SCHEME]) begin
                    r_next.state = ST_CLKEN;
                    r_next.cnt = 18'h0;
                end else if (clk_fall) begin
                    r_next.falls = r_reg.falls + 2'h1;
                    if (r_reg.falls == FALLS_LAST) begin
                        r_next.state = ST_CLKEN;
                        r_next.cnt = 18'h0;
                    end
                end
            end
            ST_CLKEN: begin
                r_next.cnt = r_reg.cnt + 18'h1;
                if (!r_reg.ctrl[`CFL_B_USRCLK] || r_reg.cnt == CU_LAST) begin
                    r_next.state = ST_INIT;
                    r_next.cnt = 18'h0;
                end
            end
            ST_INIT: begin
                // Oscillator count or user clock edges drive init
                if (r_reg.ctrl[`CFL_B_USRCLK]) begin
                    if (ucl_rise) begin
                        r_next.cnt = r_reg.cnt + 18'h1;
                        if (r_reg.cnt == USR_LAST) begin
                            r_next.state = ST_USER;
                        end
                    end
                end else begin
                    r_next.cnt = r_reg.cnt + 18'h1;
                    if (r_reg.cnt == INIT_LAST) begin
                        r_next.state = ST_USER;
                    end
                end
            end
            ST_USER: begin
                // Configuration clock no longer looked at
                r_next.cnt = 18'h0;
            end
        endcase

        // Request low restarts from anywhere past power-on
        if (!req_lvl && r_reg.state != ST_POR) begin
            r_next.state = ST_RESET;
            r_next.as_run = 1'b0;
        end

        // Pin drive follows the next state, so request fall reaches pins in 5 cycles
        r_next.status_oe = r_next.state inside {ST_POR, ST_RESET, ST_STATUS};
        r_next.done_oe = r_next.state inside {ST_POR, ST_RESET, ST_STATUS,
                                              ST_STWAIT, ST_LOAD};
        r_next.init_oe = r_reg.ctrl[`CFL_B_INITEN] &&
                         (r_next.state inside {ST_DONE, ST_CLKEN, ST_INIT});
        r_next.io_en = r_next.state == ST_USER;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            r_reg <= '{state: ST_POR, cnt: 18'h0, falls: 2'h0, ratio: 2'h0,
                       bytes: 32'h0000_0000, img_len: `CFL_IMGLEN_RST,
                       ctrl: `CFL_CTRL_RST, last_word: 32'h0000_0000,
                       clk_prev: 1'b0, ucl_prev: 1'b0, ack: 1'b0, waitreq: 1'b1,
                       rdata: 32'h0000_0000, status_oe: 1'b1, done_oe: 1'b1,
                       init_oe: 1'b0, io_en: 1'b0, as_run: 1'b0, pin_low: 1'b0};
        end else if (i_ce) begin
            r_reg <= r_next;
        end
    end

    assign o_avs_readdata = r_reg.rdata;
    assign o_avs_waitrequest = r_reg.waitreq;
    // Open-drain pins only ever pull low; release lets them float high
    assign o_status_n_out = r_reg.pin_low;
    assign o_status_n_oe = r_reg.status_oe;
    assign o_load_complete_out = r_reg.pin_low;
    assign o_load_complete_oe = r_reg.done_oe;
    assign o_init_done_out = r_reg.pin_low;
    assign o_init_done_oe = r_reg.init_oe;
    assign o_cfg_clock_out = as_link.clk_out;
    assign o_cfg_clock_oe = r_reg.as_run;
    assign o_serial_cmd_out = as_link.cmd_out;
    assign o_serial_cmd_oe = r_reg.as_run;
    assign o_user_io_en = r_reg.io_en;
    assign o_state = r_reg.state;
endmodule

// [cfl_config_loader_props.sv]
// Concurrent checks on the loader top-level ports.
// Bound into every cfl_config_loader; one clock domain, sync active-low reset.
`timescale 1ns/1ps
module cfl_config_loader_props
    import cfl_pkg::*;
#(
    parameter int unsigned POR_CYC = 26800,
    parameter int unsigned STATUS_CYC = 26800,
    parameter int unsigned INIT_CYC = 17500
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_cfg_request_n,
    input wire logic o_avs_waitrequest,
    input wire logic o_status_n_oe,
    input wire logic o_load_complete_oe,
    input wire logic o_cfg_clock_oe,
    input wire logic o_user_io_en,
    input wire cfl_pkg::cfl_state_t o_state
);
    logic [31:0] por_cnt;
    logic [31:0] st_cnt;
    logic [31:0] rel_cnt;

    // Saturating count since reset; run lengths of status pull and load-complete release
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            por_cnt <= 32'h0;
            st_cnt <= 32'h0;
            rel_cnt <= 32'h0;
        end else begin
            if (por_cnt < POR_CYC) begin
                por_cnt <= por_cnt + 32'h1;
            end
            st_cnt <= o_status_n_oe ? st_cnt + 32'h1 : 32'h0;
            rel_cnt <= o_load_complete_oe ? 32'h0 : rel_cnt + 32'h1;
        end
    end

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    wait_pulse_a: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    por_status_a: assert property (por_cnt < POR_CYC |-> o_status_n_oe)
        else $error("status released inside power-on delay");
    done_low_a: assert property (o_state inside {ST_POR, ST_STATUS, ST_STWAIT}
        |-> o_load_complete_oe)
        else $error("load-complete released before loading");
    req_resp_a: assert property ($fell(i_cfg_request_n) && o_state != ST_POR
        |-> ##[1:60] (o_status_n_oe && o_load_complete_oe))
        else $error("status or load-complete not pulled within 600 ns");
    user_leave_a: assert property ($fell(i_cfg_request_n) && o_user_io_en
        |-> ##[1:60] !o_user_io_en)
        else $error("user mode kept after request fell");
    status_len_a: assert property ($fell(o_status_n_oe) |-> st_cnt >= STATUS_CYC)
        else $error("status pulse too short");
    init_time_a: assert property ($rose(o_user_io_en) |-> rel_cnt >= INIT_CYC)
        else $error("user mode entered too early");
    user_lines_a: assert property (o_user_io_en && $past(i_cfg_request_n, 12)
        |-> !o_status_n_oe && !o_load_complete_oe)
        else $error("status or load-complete pulled in user mode");
    clk_quiet_a: assert property (o_user_io_en |-> !o_cfg_clock_oe)
        else $error("configuration clock driven in user mode");

    cover property ($rose(o_user_io_en));
    cover property ($fell(o_load_complete_oe));
    cover property ($fell(i_cfg_request_n) && o_user_io_en);
endmodule

bind cfl_config_loader cfl_config_loader_props #(
    .POR_CYC(POR_CYC), .STATUS_CYC(STATUS_CYC), .INIT_CYC(INIT_CYC)
) u_props (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cfg_request_n(i_cfg_request_n),
    .o_avs_waitrequest(o_avs_waitrequest), .o_status_n_oe(o_status_n_oe),
    .o_load_complete_oe(o_load_complete_oe), .o_cfg_clock_oe(o_cfg_clock_oe),
    .o_user_io_en(o_user_io_en), .o_state(o_state)
);

// [cfl_host_model.sv]
// Behavioural parallel passive host: burst of configuration clocks with data.
// Started by a rising i_start; clock parked low, data zero before the first burst and scrambled after each.
`timescale 1ns/1ps
module cfl_host_model (
    input wire logic i_start,
    input wire logic [7:0] i_edges,
    output logic o_cfg_clock,
    output logic [31:0] o_cfg_data,
    output logic o_busy
);
    logic [31:0] last;

    initial begin
        o_cfg_clock = 1'b0;
        o_cfg_data = 32'h0;
        o_busy = 1'b0;
        last = 32'h3c5a_a5c3;
    end

    // 80 ns period keeps under every width limit; data moves on falling edges
    always @(posedge i_start) begin
        o_busy = 1'b1;
        #3;
        repeat (i_edges) begin
            last = last + 32'h1357_9bdf;
            o_cfg_data = last;
            #40 o_cfg_clock = 1'b1;
            #40 o_cfg_clock = 1'b0;
        end
        // Released bus must not keep the last word
        o_cfg_data = ~last;
        o_busy = 1'b0;
    end
endmodule

// [cfl_config_loader_bench.sv]
// Self-checking bench: three parallel loads (x8, x16 slow-capture, x32 user-clocked
// init) with reconfiguration.
// Host model drives the link; status and load-complete are open-drain with pull-up.
`timescale 1ns/1ps
module cfl_config_loader_bench;
    import cfl_pkg::*;
    logic clk, rst_n, req_n, rd, wr, ext_hold, h_go, h_clk, h_busy, ucl;
    logic st_oe, lc_oe, id_oe, wreq, uio;
    logic [3:0] addr, sdat;
    logic [7:0] h_n;
    logic [31:0] wdat, rdat, q, c, h_dat;
    cfl_state_t st;
    int error_cnt, cmp_count, seed, k, bp, t0;
    int cyc = 0;
    wire status_w = !(st_oe || ext_hold);
    wire lc_w = !lc_oe;

    cfl_config_loader #(.POR_CYC(20), .STATUS_CYC(20), .INIT_CYC(30)) uut (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .i_cfg_request_n(req_n), .i_status_n(status_w),
        .o_status_n_out(), .o_status_n_oe(st_oe), .i_load_complete(lc_w),
        .o_load_complete_out(), .o_load_complete_oe(lc_oe), .o_init_done_out(),
        .o_init_done_oe(id_oe), .i_cfg_clock(h_clk), .o_cfg_clock_out(), .o_cfg_clock_oe(),
        .i_cfg_data(h_dat), .i_user_init_clock(ucl), .i_serial_cfg_data(sdat),
        .o_serial_cmd_out(), .o_serial_cmd_oe(), .o_user_io_en(uio), .o_state(st)
    );

    cfl_host_model host (
        .i_start(h_go), .i_edges(h_n), .o_cfg_clock(h_clk), .o_cfg_data(h_dat),
        .o_busy(h_busy)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Free-running user init clock; only counted when its option is set
    initial begin
        ucl = 1'b0;
        forever #40 ucl = ~ucl;
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask

    // Holds the request until waitrequest is seen low, then releases it
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 100);
        r = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 100) error_cnt++;
    endtask

    task automatic send(input logic [7:0] n);
        int t;
        t = 0;
        @(posedge clk);
        h_n <= n;
        h_go <= 1'b1;
        @(posedge clk);
        h_go <= 1'b0;
        do begin
            @(negedge clk);
            t++;
        end while (h_busy === 1'b1 && t < 2000);
    endtask

    task automatic wait_st(input cfl_state_t s);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (st !== s && n < 80000);
        chk(32'(st), 32'(s));
    endtask

    initial begin
        seed = 58830;
        error_cnt = 0;
        cmp_count = 0;
        {rst_n, req_n, rd, wr, ext_hold, h_go} = 6'b010000;
        addr = 4'h0;
        sdat = 4'h0;
        h_n = 8'h0;
        wdat = 32'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk(32'(st_oe), 32'h1);
        chk(32'(lc_oe), 32'h1);
        bus(4'h0, 1'b0, 32'h0, q);
        chk(q, 32'h0);
        bus(4'h4, 1'b0, 32'h0, q);
        chk(q, 32'h0);
        bus(4'h2, 1'b0, 32'h0, q);
        chk(q, 32'h0);
        $display("reset checks done");
        for (int i = 0; i < 3; i++) begin
            bp = (i == 0) ? 1 : (i == 1) ? 2 : 4;
            k = 2 + int'($unsigned($random(seed)) % 4);
            @(posedge clk);
            sdat <= 4'($random(seed));
            if (i > 0) begin
                req_n <= 1'b0;
                ext_hold <= (i == 2);
                repeat (60) @(negedge clk);
                chk(32'(st_oe), 32'h1);
                chk(32'(lc_oe), 32'h1);
                chk(32'(uio), 32'h0);
                repeat (140) @(posedge clk);
                req_n <= 1'b1;
                repeat (100) @(negedge clk);
                if (i == 2) chk(32'(st == ST_LOAD), 32'h0);
                @(posedge clk);
                ext_hold <= 1'b0;
            end
            bus(4'h0, 1'b1, (i == 0) ? 32'h0 : (i == 1) ? 32'h212 : 32'hc, q);
            bus(4'h4, 1'b1, 32'(k * bp), q);
            wait_st(ST_LOAD);
            repeat (200) @(posedge clk);
            send(8'((i == 1) ? 4 * (k - 1) : k - 1));
            bus(4'hc, 1'b0, 32'h0, q);
            chk(q, 32'((k - 1) * bp));
            @(negedge clk);
            chk(32'(lc_oe), 32'h1);
            send((i == 1) ? 8'h4 : 8'h1);
            repeat (10) @(negedge clk);
            chk(32'(lc_oe), 32'h0);
            send(8'h2);
            wait_st(ST_INIT);
            t0 = cyc;
            chk(32'(id_oe), 32'(i == 1));
            wait_st(ST_USER);
            if (i == 2) chk(32'(cyc - t0 >= (8576 - 1) * 8), 32'h1);
            chk(32'(uio), 32'h1);
            chk(32'({st_oe, lc_oe}), 32'h0);
            bus(4'h8, 1'b0, 32'h0, q);
            chk(q, 32'h0000_00f8);
            bus(4'hc, 1'b0, 32'h0, c);
            send(8'h3);
            bus(4'hc, 1'b0, 32'h0, q);
            chk(q, c);
            $display("load test %0d done", i);
        end
        print_verdict();
    end
endmodule
